// ### core/ext_bus_cfg.svh
// Purpose: constants for the external bus mode, ready and lock block
// Assumes: 40 MHz sys_clk, one state time per bus phase step
// Notes:   offsets, field positions and counts as macros
`ifndef EXT_BUS_CFG_SVH
`define EXT_BUS_CFG_SVH
`define CFG_BYTE_ADDR    16'h2018
`define CFG_WIDTH_BIT    1
`define CFG_WRSTB_BIT    2
`define CFG_ADV_BIT      3
`define CFG_WAIT_LO_BIT  4
`define CFG_WAIT_HI_BIT  5
`define CFG_LOCK_LO_BIT  6
`define CFG_LOCK_HI_BIT  7
`define CFG_RESET_VAL    8'hff
`define RD_PROT_BASE     16'h2020
`define WR_PROT_BASE     16'h2000
`define PROT_TOP_SMALL   16'h3fff
`define PROT_TOP_LARGE   16'h5fff
`define SPC_LIMIT_SMALL  16'h3ffa
`define SPC_LIMIT_LARGE  16'h5ffa
`define KEY_EXT_BASE     16'h4020
`define KEY_INT_BASE     16'h2020
`define KEY_LEN          5'h10
`define WAIT_UNCAPPED    2'h3
`endif

// ### core/ext_bus_pkg.sv
// Purpose: types for the external bus mode, ready and lock block
// Assumes: constants live in ext_bus_cfg.svh
// Notes:   request and strobe groups travel as packed structs
package ext_bus_pkg;
   typedef struct packed {
      logic        write;
      logic        word;
      logic        fetch;
      logic [15:0] addr;
      logic [15:0] wdata;
   } bus_req_t;

   typedef struct packed {
      logic ale;
      logic address_valid_n;
      logic wr_n;
      logic rd_n;
      logic upper_lane_enable_n;
      logic low_lane_store_n;
      logic high_lane_store_n;
   } strobes_t;
endpackage : ext_bus_pkg

// ### core/key_store.sv
// Purpose: small register memory holding the sixteen byte internal key
// Assumes: written by the loader, read one byte per cycle
// Notes:   read data comes from a register
`timescale 1ns/10ps
`default_nettype none
module key_store (
   input  wire logic       sys_clk,
   input  wire logic       wr_en,
   input  wire logic [3:0] wr_idx,
   input  wire logic [7:0] wr_data,
   input  wire logic [3:0] rd_idx,
   output var  logic [7:0] rd_data_q
);
   logic [7:0] mem_q [16];

   // storage, no reset needed for the key array
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem_q[wr_idx] <= wr_data;
      end
      rd_data_q <= mem_q[rd_idx];
   end
endmodule : key_store
`default_nettype wire

// ### core/ext_bus_ctrl.sv
// Purpose: external bus width, strobe mode, wait cap and program lock
// Assumes: cpu issues one request at a time; config byte given at reset
// Notes:   one phase per sys_clk stands for one state time
//
// Summary of operation
// - config width bit or width pin low gives 16-bit address, 8-bit data
// - both width bit and pin high gives 16-bit data path
// - internal accesses always run at full 16-bit width
// - 16-bit cycles multiplex address and data on both lanes, latch strobe
// - 8-bit cycles multiplex low lane only; upper lane holds address high
// - width pin sampled every external cycle when width bit latched one
// - 8-bit bus word write adds two states, word read adds one
// - 8-bit bus empty-queue fetch adds one state per extra byte
// - standard mode drives write strobe and upper lane enable, latch strobe
// - low strobe for even bytes and words, high for odd bytes and words
// - split mode uses low strobe for every 8-bit bus write
// - bit 3 zero gives active-low address valid strobe to cycle end
// - both bits zero give address valid and split strobes together
// - ready low inserts waits until ready rises or cap reached
// - wait cap code 00=1, 01=2, 10=3, 11=no cap
// - lock code 00 read+write, 01 read, 10 write, 11 none
// - read protect from 2020h, write protect from 2000h, to memory top
// - protected reads only from internal code or keyed test mode; protected writes always blocked
// - lock check uses slave pc; code above limit address is refused
// - refused protected read still runs, returns indeterminate data
// - test read of protected memory needs external key match
// - config register loaded at reset and then held
// - ready low freezes bus lines; resume after ready rises
`timescale 1ns/10ps
`default_nettype none
`include "ext_bus_cfg.svh"
module ext_bus_ctrl (
   input  wire logic                  sys_clk,
   input  wire logic                  sys_rst,
   input  wire logic [7:0]            boot_config_byte,
   input  wire logic                  large_variant,
   input  wire ext_bus_pkg::bus_req_t req,
   input  wire logic                  req_valid,
   input  wire logic                  req_internal,
   input  wire logic                  queue_empty,
   input  wire logic [1:0]            opcode_len,
   input  wire logic [15:0]           slave_pc,
   input  wire logic                  exec_internal,
   input  wire logic                  test_mode,
   input  wire logic                  key_wr,
   input  wire logic [3:0]            key_wr_idx,
   input  wire logic [7:0]            key_wr_data,
   input  wire logic                  width_select_pin,
   input  wire logic                  ready_pin,
   input  wire logic [15:0]           port_in,
   output logic [15:0]                port_out,
   output logic [15:0]                port_oe,
   output ext_bus_pkg::strobes_t      strobes,
   output logic                       opcode_fetch_flag,
   output logic                       bus_clock_out,
   output logic                       busy,
   output logic                       done,
   output logic [15:0]                rdata,
   output logic                       refused,
   output logic [2:0]                 stretch_states,
   output logic                       key_ok,
   output logic [7:0]                 boot_config_reg
);
   typedef enum logic [2:0] {IDLE, ADDR, STROBE, WAITS, FINISH, KEYCHK} phase_t;

   phase_t                phase_q;
   ext_bus_pkg::bus_req_t cur_q;
   logic                  wide_q, prot_q, int_q, key_run_q, key_bad_q, key_act_q;
   logic [1:0]            wait_cnt_q;
   logic [4:0]            key_idx_q;
   logic [2:0]            rdy_sync_q;
   logic                  rdy_q;
   logic [7:0]            key_byte;

   // one decode used for both read and write region checks
   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   // ready pin passes three flops; change accepted when 2nd and 3rd agree
   always_ff @(posedge sys_clk) begin
      rdy_sync_q <= {rdy_sync_q[1:0], ready_pin};
      if (rdy_sync_q[1] == rdy_sync_q[2]) begin
         rdy_q <= rdy_sync_q[2];
      end
   end

   // configuration held from reset on
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         boot_config_reg <= boot_config_byte;
      end
   end

   wire        cfg_wide  = boot_config_reg[`CFG_WIDTH_BIT];
   wire        wrstb_on  = ~boot_config_reg[`CFG_WRSTB_BIT];
   wire        adv_on    = ~boot_config_reg[`CFG_ADV_BIT];
   wire [1:0]  wait_code = boot_config_reg[`CFG_WAIT_HI_BIT:`CFG_WAIT_LO_BIT];
   wire [1:0]  lock_code = boot_config_reg[`CFG_LOCK_HI_BIT:`CFG_LOCK_LO_BIT];
   // width from latched bit and-combined with the pin each cycle
   wire        wide_now  = cfg_wide & width_select_pin;
   // lock field decode
   wire        rd_lock   = ~lock_code[1];
   wire        wr_lock   = ~lock_code[0];
   wire [15:0] mem_top   = large_variant ? `PROT_TOP_LARGE : `PROT_TOP_SMALL;
   wire [15:0] spc_lim   = large_variant ? `SPC_LIMIT_LARGE : `SPC_LIMIT_SMALL;
   wire        rd_area   = in_range(req.addr, `RD_PROT_BASE, mem_top);
   wire        wr_area   = in_range(req.addr, `WR_PROT_BASE, mem_top);
   // reads allowed from internal code at or below the slave pc limit, or in test mode with key_ok
   wire        rd_ok     = (exec_internal && slave_pc <= spc_lim) ||
                           (test_mode && key_ok);
   wire        deny      = req.write ? (wr_lock & wr_area)
                                     : (rd_lock & rd_area & ~rd_ok);
   // wait cap reached: code 00 gives 1, 01 gives 2, 10 gives 3
   // counted only inside waits, so code 00 still yields one wait state
   wire        cap_hit   = (phase_q == WAITS) && (wait_code != `WAIT_UNCAPPED) &&
                           (wait_cnt_q == wait_code);
   wire        go_on     = rdy_q | cap_hit;
   wire        byte_lane = ~wide_q;
   // stretch count on narrow bus
   wire [2:0]  len_m1    = (opcode_len == 2'h0) ? 3'h0 : {1'b0, opcode_len} - 3'h1;
   wire [2:0]  stretch_d = (~wide_now && req.word) ?
                           (req.fetch ? (queue_empty ? len_m1 : 3'h0)
                                      : (req.write ? 3'h2 : 3'h1))
                           : 3'h0;
   wire        key_done  = key_idx_q == `KEY_LEN;
   wire        key_match = port_in[7:0] == key_byte;

   key_store u_key (
      .sys_clk   (sys_clk),
      .wr_en     (key_wr),
      .wr_idx    (key_wr_idx),
      .wr_data   (key_wr_data),
      .rd_idx    (key_idx_q[3:0]),
      .rd_data_q (key_byte)
   );

   // bus phase sequencer
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         phase_q    <= IDLE;
         wait_cnt_q <= 2'h0;
         wide_q     <= 1'b0;
         prot_q     <= 1'b0;
         int_q      <= 1'b0;
         cur_q      <= '0;
         key_idx_q  <= 5'h00;
         key_run_q  <= 1'b0;
         key_bad_q  <= 1'b0;
         key_act_q  <= 1'b0;
         key_ok     <= 1'b0;
      end else begin
         unique case (phase_q)
            IDLE: begin
               if (test_mode && !key_ok && !key_run_q) begin
                  phase_q   <= ADDR;
                  key_act_q <= 1'b1;
                  prot_q    <= 1'b0;
                  int_q     <= 1'b0;
                  key_run_q <= 1'b1;
                  key_idx_q <= 5'h00;
                  key_bad_q <= 1'b0;
                  cur_q     <= '0;
                  cur_q.addr <= `KEY_EXT_BASE;
                  wide_q    <= 1'b0;
               end else if (req_valid) begin
                  cur_q  <= req;
                  wide_q <= req_internal | wide_now;
                  prot_q <= deny;
                  int_q  <= req_internal;
                  phase_q <= req_internal ? FINISH : ADDR;
               end
            end
            ADDR:   phase_q <= STROBE;
            STROBE: begin
               wait_cnt_q <= 2'h0;
               phase_q    <= go_on ? FINISH : WAITS;
            end
            WAITS: begin
               wait_cnt_q <= wait_cnt_q + 2'h1;
               if (go_on) begin
                  phase_q <= FINISH;
               end
            end
            FINISH: begin
               // key byte is on the bus while the read strobe is still low
               if (key_act_q) begin
                  if (!key_match) begin
                     key_bad_q <= 1'b1;
                  end
                  key_idx_q <= key_idx_q + 5'h01;
                  phase_q   <= KEYCHK;
               end else begin
                  phase_q <= IDLE;
               end
            end
            KEYCHK: begin
               // one full narrow read cycle per external key byte
               if (key_done) begin
                  key_ok    <= ~key_bad_q;
                  key_act_q <= 1'b0;
                  phase_q   <= IDLE;
               end else begin
                  cur_q.addr <= `KEY_EXT_BASE + {11'h000, key_idx_q};
                  phase_q    <= ADDR;
               end
            end
            default: phase_q <= IDLE;
         endcase
         if (!test_mode) begin
            key_run_q <= 1'b0;
         end
      end
   end

   // address phase drives address; strobe phase drives write data
   wire        addr_ph  = (phase_q == ADDR);
   wire        data_ph  = (phase_q == STROBE) || (phase_q == WAITS);
   wire        ext_cyc  = (addr_ph || data_ph) && !int_q;
   wire        wr_cyc   = data_ph && cur_q.write && !prot_q && !int_q;
   wire        rd_cyc   = data_ph && !cur_q.write && !int_q;
   wire        odd      = cur_q.addr[0];
   wire [15:0] out_d    = addr_ph ? cur_q.addr
                        : (byte_lane ? {cur_q.addr[15:8], cur_q.wdata[7:0]}
                                     : cur_q.wdata);
   wire [15:0] oe_d     = addr_ph ? 16'hffff
                        : (wr_cyc ? 16'hffff
                                  : (byte_lane && data_ph ? 16'hff00 : 16'h0000));
   wire        split    = wrstb_on;
   wire        lo_st    = wr_cyc && (byte_lane || cur_q.word || !odd);
   wire        hi_st    = wr_cyc && !byte_lane && (cur_q.word || odd);
   wire        upper_en = ext_cyc && !byte_lane && (cur_q.word || odd);

   // strobe and port registers; outputs come straight from flops
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         port_out          <= 16'h0000;
         port_oe           <= 16'h0000;
         strobes           <= 7'h7f;
         strobes.ale       <= 1'b0;
         opcode_fetch_flag <= 1'b0;
         bus_clock_out     <= 1'b0;
      end else begin
         port_out <= out_d;
         port_oe  <= oe_d;
         strobes.ale             <= ~adv_on & addr_ph;
         strobes.address_valid_n <= ~(adv_on & ext_cyc);
         strobes.wr_n            <= ~(~split & wr_cyc);
         strobes.upper_lane_enable_n <= ~(~split & upper_en);
         strobes.low_lane_store_n  <= ~(split & lo_st);
         strobes.high_lane_store_n <= ~(split & hi_st);
         strobes.rd_n            <= ~(rd_cyc & ~addr_ph);
         opcode_fetch_flag <= ext_cyc & cur_q.fetch & ~cur_q.write;
         bus_clock_out     <= ~bus_clock_out;
      end
   end

   // answer to the cpu; denied read returns junk from the bus
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         busy           <= 1'b0;
         done           <= 1'b0;
         rdata          <= 16'h0000;
         refused        <= 1'b0;
         stretch_states <= 3'h0;
      end else begin
         busy <= (phase_q != IDLE) || req_valid;
         done <= (phase_q == FINISH);
         if (phase_q == IDLE && req_valid) begin
            stretch_states <= stretch_d;
         end
         if (phase_q == FINISH) begin
            refused <= prot_q;
            // narrow cycle carries one byte; upper lane held address, not data
            rdata   <= prot_q ? ~port_in
                              : (byte_lane ? {8'h00, port_in[7:0]} : port_in);
         end
      end
   end

   chk_wait_cap: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (phase_q == WAITS && wait_code != `WAIT_UNCAPPED) |-> wait_cnt_q <= wait_code)
      else $error("wait count passed its cap");
   chk_cfg_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $stable(boot_config_reg)) else $error("config changed outside reset");
   chk_prot_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (phase_q == STROBE && prot_q && cur_q.write) |=> strobes.wr_n && strobes.low_lane_store_n)
      else $error("protected write was strobed");
   chk_freeze_ready: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (phase_q == WAITS && !go_on) |=> phase_q == WAITS && $stable(cur_q.addr))
      else $error("bus moved while not ready");
   chk_narrow_upper: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (data_ph && byte_lane && !int_q) |=> port_oe[15:8] == 8'hff && port_out[15:8] == cur_q.addr[15:8])
      else $error("upper lane lost address in narrow cycle");
   chk_adv_mode: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !adv_on |=> strobes.address_valid_n) else $error("address valid in latch mode");
   chk_split_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !wrstb_on |=> strobes.low_lane_store_n && strobes.high_lane_store_n)
      else $error("split strobe outside split mode");
   chk_key_ok: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(key_ok) |-> $past(phase_q) == KEYCHK && !$past(key_bad_q))
      else $error("key accepted without full match");
endmodule : ext_bus_ctrl
`default_nettype wire

// ### testbench/ext_mem_model.sv
// Purpose: external memory and slow device on the far side of the bus
// Assumes: 256-byte store aliased on the address low byte
// Notes:   a released bus shows a changing pattern, never the last value
`timescale 1ns/10ps
`default_nettype none
module ext_mem_model (
   input  wire logic                  sys_clk,
   input  wire ext_bus_pkg::strobes_t strobes,
   input  wire logic [15:0]           port_out,
   input  wire logic                  narrow,
   input  wire logic [7:0]            wait_len,
   output logic [15:0]                port_in,
   output logic                       ready_pin,
   output logic                       lo_seen,
   output logic                       hi_seen
);
   logic [7:0]  mem [256];
   logic [15:0] addr_q, last_q, rd_val;
   logic [7:0]  wcnt_q, a;
   logic        ale_q, adv_n_q, lo_w, hi_w, start, go_q, rd_n_q;
   // cycle start on latch strobe rising or address valid falling
   assign start = (strobes.ale && !ale_q) || (!strobes.address_valid_n && adv_n_q);
   assign a = addr_q[7:0];
   // lane decode for standard and split strobe styles
   assign lo_w = !strobes.low_lane_store_n || (!strobes.wr_n && (narrow || !a[0]));
   assign hi_w = !strobes.high_lane_store_n
               || (!strobes.wr_n && !narrow && !strobes.upper_lane_enable_n);
   assign rd_val = narrow ? {~last_q[15:8], mem[a]} : {mem[a | 8'h01], mem[a & 8'hfe]};
   // data only while the read strobe is low
   assign port_in = !strobes.rd_n ? rd_val : ~last_q;
   // slow device: ready idles low, rises after wait_len cycles
   // idling low lets the three-flop sync see it before the strobe phase
   assign ready_pin = (wait_len == 8'h00) || go_q;
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'h00;
      last_q = 16'h0000;
      wcnt_q = 8'h00;
      go_q = 1'b0;
      rd_n_q = 1'b1;
   end
   // latch address, count waits, store while a write strobe is low
   always @(posedge sys_clk) begin
      ale_q <= strobes.ale;
      adv_n_q <= strobes.address_valid_n;
      last_q <= port_in;
      rd_n_q <= strobes.rd_n;
      if (start) begin
         addr_q <= port_out;
         wcnt_q <= wait_len;
         go_q <= 1'b0;
         lo_seen <= 1'b0;
         hi_seen <= 1'b0;
      end else if (strobes.rd_n && !rd_n_q) begin
         wcnt_q <= 8'h00;
         go_q <= 1'b0;
      end else if (wcnt_q != 8'h00) begin
         wcnt_q <= wcnt_q - 8'h01;
         if (wcnt_q == 8'h01) go_q <= 1'b1;
      end
      if (lo_w) begin
         lo_seen <= 1'b1;
         mem[narrow ? a : a & 8'hfe] <= port_out[7:0];
      end
      if (hi_w) begin
         hi_seen <= 1'b1;
         mem[a | 8'h01] <= port_out[15:8];
      end
   end
endmodule : ext_mem_model
`default_nettype wire

// ### testbench/tb.sv
// Purpose: self-checking bench for bus width, strobe style, wait cap and lock
// Assumes: ext_mem_model on the far side; config byte given during reset
// Notes:   a watcher pairs each done pulse with the oldest queued note
`timescale 1ns/10ps
`default_nettype none
`define CHECK(g, e) begin \
   samples_checked++; \
   if ((g) !== (e)) begin \
      n_errors++; \
      $display("unexpected at %0t got %h exp %h", $time, g, e); \
   end \
end
module tb;
   typedef struct packed {
      logic        cr;
      logic [15:0] v;
      logic        r;
      logic [3:0]  s;
   } note_t;
   logic        sys_clk, sys_rst, large_variant, req_valid, req_internal, queue_empty;
   logic        exec_internal, test_mode, key_wr, width_select_pin, ready_pin, narrow;
   logic        lo_seen, hi_seen, bus_clock_out, busy, done, refused, key_ok, fetch_flag;
   logic [7:0]  boot_config_byte, cfg, key_wr_data, wait_len, boot_config_reg;
   logic [3:0]  key_wr_idx;
   logic [1:0]  opcode_len, exp_lh [4];
   logic [2:0]  stretch_states;
   logic [15:0] slave_pc, port_in, port_out, port_oe, rdata, d;
   ext_bus_pkg::bus_req_t req;
   ext_bus_pkg::strobes_t strobes;
   int          n_errors, samples_checked, lat, n_rd, k;
   note_t       notes[$];
   note_t       nt;
   assign narrow = !(width_select_pin && cfg[1]);
   ext_bus_ctrl dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .boot_config_byte(boot_config_byte),
      .large_variant(large_variant), .req(req), .req_valid(req_valid),
      .req_internal(req_internal), .queue_empty(queue_empty), .opcode_len(opcode_len),
      .slave_pc(slave_pc), .exec_internal(exec_internal), .test_mode(test_mode),
      .key_wr(key_wr), .key_wr_idx(key_wr_idx), .key_wr_data(key_wr_data),
      .width_select_pin(width_select_pin), .ready_pin(ready_pin), .port_in(port_in),
      .port_out(port_out), .port_oe(port_oe), .strobes(strobes),
      .opcode_fetch_flag(fetch_flag), .bus_clock_out(bus_clock_out), .busy(busy),
      .done(done), .rdata(rdata), .refused(refused), .stretch_states(stretch_states),
      .key_ok(key_ok), .boot_config_reg(boot_config_reg));
   ext_mem_model ext (.sys_clk(sys_clk), .strobes(strobes), .port_out(port_out),
      .narrow(narrow), .wait_len(wait_len), .port_in(port_in), .ready_pin(ready_pin),
      .lo_seen(lo_seen), .hi_seen(hi_seen));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // read strobe activity, to show internal accesses stay off the pins
   always @(posedge sys_clk) if (strobes.rd_n === 1'b0) n_rd++;
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test
   // reset with a config byte, then change the byte to show it is held
   task automatic rst(input logic [7:0] c);
      cfg = c;
      boot_config_byte = c;
      sys_rst = 1'b1;
      repeat (10) @(negedge sys_clk);
      sys_rst = 1'b0;
      boot_config_byte = ~c;
      @(negedge sys_clk);
      `CHECK(boot_config_reg, c)
   endtask : rst
   // one request held until busy shows it taken; bounded wait for done
   task automatic acc(input logic w, wd, input logic [15:0] a, dat,
                      input logic cr, input logic [15:0] v, input logic r,
                      input logic [3:0] s);
      int i;
      notes.push_back('{cr, v, r, s});
      req = '{write: w, word: wd, fetch: 1'b0, addr: a, wdata: dat};
      req_valid = 1'b1;
      for (i = 0; i < 300 && done !== 1'b1; i++) begin
         @(negedge sys_clk);
         if (busy === 1'b1) req_valid = 1'b0;
      end
      req_valid = 1'b0;
      lat = i;
      if (i == 300) begin
         n_errors++;
         end_of_test();
      end
      @(negedge sys_clk);
   endtask : acc
   // watcher: results stand one edge after the done pulse
   initial begin
      forever begin
         @(negedge sys_clk);
         if (done === 1'b1 && notes.size() > 0) begin
            @(negedge sys_clk);
            nt = notes.pop_front();
            if (nt.cr) `CHECK(rdata, nt.v)
            `CHECK(refused, nt.r)
            if (nt.s[3]) `CHECK(stretch_states, nt.s[2:0])
         end
      end
   end
   initial begin
      {large_variant, req_valid, req_internal, exec_internal, test_mode, key_wr} = 6'h00;
      {key_wr_idx, key_wr_data, slave_pc, wait_len} = 36'h0;
      {n_errors, samples_checked, n_rd} = 96'h0;
      req = '0;
      queue_empty = 1'b1;
      opcode_len = 2'h3;
      width_select_pin = 1'b1;
      exp_lh = '{2'h2, 2'h1, 2'h3, 2'h2};
      void'($urandom(32'h5a62));
      d = 16'($urandom);
      rst(8'hff);
      acc(1'b1, 1'b1, 16'h0040, d, 1'b0, d, 1'b0, 4'h8);
      acc(1'b0, 1'b1, 16'h0040, d, 1'b1, d, 1'b0, 4'h8);
      k = n_rd;
      req_internal = 1'b1;
      acc(1'b0, 1'b1, 16'h0040, d, 1'b0, d, 1'b0, 4'h0);
      `CHECK(n_rd, k)
      req_internal = 1'b0;
      // narrow cycles picked per cycle by the width pin
      width_select_pin = 1'b0;
      acc(1'b1, 1'b1, 16'h0050, d, 1'b0, d, 1'b0, 4'ha);
      acc(1'b0, 1'b1, 16'h0050, d, 1'b1, {8'h00, d[7:0]}, 1'b0, 4'h9);
      width_select_pin = 1'b1;
      acc(1'b0, 1'b1, 16'h0050, d, 1'b1, {8'h00, d[7:0]}, 1'b0, 4'h8);
      // split lane strobes with latch strobe, then with address valid
      for (int m = 0; m < 2; m++) begin
         rst(m ? 8'hf3 : 8'hfb);
         for (int j = 0; j < 4; j++) begin
            width_select_pin = (j != 3);
            acc(1'b1, j == 2, 16'h0060 + 16'(j), {2{d[7:0]}}, 1'b0, d, 1'b0, 4'h0);
            `CHECK({lo_seen, hi_seen}, exp_lh[j])
         end
      end
      width_select_pin = 1'b1;
      // ready held low far longer than any cap
      wait_len = 8'h28;
      for (int c = 0; c < 4; c++) begin
         rst({2'h3, c[1:0], 4'hf});
         acc(1'b0, 1'b1, 16'h0040, d, 1'b0, d, 1'b0, 4'h0);
         `CHECK(c == 3 ? lat >= 40 : lat <= 12, 1'b1)
      end
      wait_len = 8'h00;
      // every lock code at both protection boundaries
      for (int c = 0; c < 4; c++) begin
         rst({c[1:0], 6'h3f});
         exec_internal = 1'b1;
         acc(1'b1, 1'b1, 16'h2000, d, 1'b0, d, !c[0], 4'h0);
         exec_internal = 1'b0;
         acc(1'b1, 1'b1, 16'h1ffe, d, 1'b0, d, 1'b0, 4'h0);
         acc(1'b0, 1'b1, 16'h2020, d, 1'b0, d, !c[1], 4'h0);
         acc(1'b0, 1'b1, 16'h201e, d, 1'b0, d, 1'b0, 4'h0);
      end
      // read lock: external code refused, internal code up to the pc limit
      rst(8'h7f);
      acc(1'b1, 1'b1, 16'h2100, d, 1'b0, d, 1'b0, 4'h0);
      acc(1'b0, 1'b1, 16'h2100, d, 1'b1, ~d, 1'b1, 4'h0);
      exec_internal = 1'b1;
      slave_pc = 16'h3ffa;
      acc(1'b0, 1'b1, 16'h2100, d, 1'b1, d, 1'b0, 4'h0);
      slave_pc = 16'h3ffb;
      acc(1'b0, 1'b1, 16'h2100, d, 1'b0, d, 1'b1, 4'h0);
      large_variant = 1'b1;
      acc(1'b0, 1'b1, 16'h2100, d, 1'b0, d, 1'b0, 4'h0);
      // test mode reads the external key copy and must find it equal
      rst(8'h3f);
      width_select_pin = 1'b0;
      for (int j = 0; j < 16; j++) begin
         key_wr = 1'b1;
         key_wr_idx = 4'(j);
         key_wr_data = 8'($urandom);
         ext.mem[8'h20 + 8'(j)] = key_wr_data;
         @(negedge sys_clk);
      end
      key_wr = 1'b0;
      test_mode = 1'b1;
      for (k = 0; k < 2000 && key_ok !== 1'b1; k++) @(negedge sys_clk);
      `CHECK(key_ok, 1'b1)
      `CHECK(notes.size(), 0)
      end_of_test();
   end
endmodule : tb
`default_nettype wire
